// ### bse_consts.vh
// Constants for the byte subtract execute unit
`ifndef BSE_CONSTS_VH
`define BSE_CONSTS_VH

// Register byte offsets
`define BSE_OFF_CTRL      12'h000
`define BSE_OFF_INSTR     12'h004
`define BSE_OFF_WORK      12'h008
`define BSE_OFF_BANK      12'h00c
`define BSE_OFF_INDEX     12'h010
`define BSE_OFF_STATUS    12'h014
`define BSE_OFF_MEM_ADDR  12'h018
`define BSE_OFF_MEM_DATA  12'h01c

// Field positions
`define BSE_CTRL_EXT      0
`define BSE_STAT_C        0
`define BSE_STAT_DC       1
`define BSE_STAT_Z        2
`define BSE_STAT_OV       3
`define BSE_STAT_N        4
`define BSE_STAT_BUSY     8
`define BSE_STAT_BADOP    9
`define BSE_FILE_DEST     9
`define BSE_FILE_ACCESS   8

// Reset values
`define BSE_RST_CTRL      1'b0
`define BSE_RST_WORK      8'h00
`define BSE_RST_BANK      4'h0
`define BSE_RST_INDEX     12'h000
`define BSE_RST_FLAGS     5'h00
`define BSE_RST_INSTR     16'h0000
`define BSE_RST_MEM_ADDR  12'h000

// Opcodes and addressing
`define BSE_OP_LIT        8'h08
`define BSE_OP_FILE       6'h17
`define BSE_ACCESS_LIMIT  8'h5f
`define BSE_ACCESS_HI     4'hf
`define BSE_ACCESS_LO     4'h0

`endif

// ### bse_exec_unit.v
// APB-controlled execute unit for the two byte subtract instructions
//
// Summary of operation
// - Literal subtract: literal minus working, into working
// - File subtract: memory byte minus working register
// - Destination bit zero writes working register
// - Destination bit one writes memory byte
// - Access bit zero selects the access bank
// - Access bit one joins bank select
// - Extended mode: offsets up to 95 indexed
// - Four phases: decode, read, process, write
`timescale 1ns/10ps
`default_nettype none
`include "bse_consts.vh"

module bse_exec_unit #(
  parameter ADDR_W = 12
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         busy
);

  localparam DEPTH = 1 << ADDR_W;

  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_DEC   = 3'd1;
  localparam [2:0] ST_READ  = 3'd2;
  localparam [2:0] ST_PROC  = 3'd3;
  localparam [2:0] ST_WRITE = 3'd4;

  reg  [7:0]        mem [0:DEPTH-1];
  reg  [2:0]        state;
  reg  [2:0]        next_state;
  reg               ext_mode;
  reg  [7:0]        work;
  reg  [3:0]        bank_select_register;
  reg  [11:0]       index_base;
  reg  [4:0]        flags;
  reg               bad_op;
  reg  [15:0]       opcode;
  reg  [ADDR_W-1:0] mem_addr;
  reg               is_file;
  reg  [ADDR_W-1:0] mem_ptr;
  reg  [7:0]        operand;
  reg  [7:0]        result;
  reg  [4:0]        new_flags;
  reg  [31:0]       read_mux;
  reg               mapped;

  wire              access;
  wire              commit;
  wire              commit_wr;
  wire              instr_lit;
  wire              instr_file;
  wire [7:0]        alu_diff;
  wire              alu_n;
  wire              alu_ov;
  wire              alu_c;
  wire              alu_dc;
  wire              alu_z;
  wire              mem_we;
  wire [ADDR_W-1:0] mem_wa;
  wire [7:0]        mem_wd;

  // Resolves the 8-bit file operand to a data-memory address
  function [ADDR_W-1:0] file_addr;
    input [7:0]  f;
    input        a_bit;
    input [3:0]  bank;
    input        ext;
    input [11:0] base;
    reg   [11:0] full;
    begin
      full = 12'h000;
      if (a_bit) begin
        full = {bank, f};
      end else if (ext && (f <= `BSE_ACCESS_LIMIT)) begin
        full = base + {4'h0, f};
      end else if (f <= `BSE_ACCESS_LIMIT) begin
        full = {`BSE_ACCESS_LO, f};
      end else begin
        full = {`BSE_ACCESS_HI, f};
      end
      file_addr = full[ADDR_W-1:0];
    end
  endfunction

  // Opcode class checks used at start; decode uses the file check only
  function is_lit_op;
    input [15:0] op;
    begin
      is_lit_op = (op[15:8] == `BSE_OP_LIT);
    end
  endfunction

  function is_file_op;
    input [15:0] op;
    begin
      is_file_op = (op[15:10] == `BSE_OP_FILE);
    end
  endfunction

  assign access     = psel & penable;
  assign commit     = access & pready;
  assign commit_wr  = commit & pwrite & ~pslverr;
  assign instr_lit  = is_lit_op(pwdata[15:0]);
  assign instr_file = is_file_op(pwdata[15:0]);

  bse_sub_alu u_alu (
    .minuend (operand),
    .work    (work),
    .diff    (alu_diff),
    .flag_n  (alu_n),
    .flag_ov (alu_ov),
    .flag_c  (alu_c),
    .flag_dc (alu_dc),
    .flag_z  (alu_z)
  );

  // Read mux and address decode
  always @* begin
    read_mux = 32'h0000_0000;
    mapped   = 1'b1;
    case (paddr)
      `BSE_OFF_CTRL: begin
        read_mux[`BSE_CTRL_EXT] = ext_mode;
      end
      `BSE_OFF_INSTR: begin
        read_mux[15:0] = opcode;
      end
      `BSE_OFF_WORK: begin
        read_mux[7:0] = work;
      end
      `BSE_OFF_BANK: begin
        read_mux[3:0] = bank_select_register;
      end
      `BSE_OFF_INDEX: begin
        read_mux[11:0] = index_base;
      end
      `BSE_OFF_STATUS: begin
        read_mux[4:0]             = flags;
        read_mux[`BSE_STAT_BUSY]  = busy;
        read_mux[`BSE_STAT_BADOP] = bad_op;
      end
      `BSE_OFF_MEM_ADDR: begin
        read_mux[ADDR_W-1:0] = mem_addr;
      end
      `BSE_OFF_MEM_DATA: begin
        read_mux[7:0] = mem[mem_addr];
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // One wait state per access; writes during execution are refused
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= access & ~pready;
      if (access & ~pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : read_mux;
        pslverr <= ~mapped | (pwrite & busy);
      end else begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  // Instruction phase sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (commit_wr && (paddr == `BSE_OFF_INSTR) &&
            (instr_lit || instr_file)) begin
          next_state = ST_DEC;
        end
      end
      ST_DEC: begin
        next_state = ST_READ;
      end
      ST_READ: begin
        next_state = ST_PROC;
      end
      ST_PROC: begin
        next_state = ST_WRITE;
      end
      ST_WRITE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= ST_IDLE;
      busy      <= 1'b0;
      is_file   <= 1'b0;
      mem_ptr   <= {ADDR_W{1'b0}};
      operand   <= 8'h00;
      result    <= 8'h00;
      new_flags <= `BSE_RST_FLAGS;
    end else begin
      state <= next_state;
      busy  <= (next_state != ST_IDLE);
      case (state)
        ST_DEC: begin
          is_file <= is_file_op(opcode);
          mem_ptr <= file_addr(opcode[7:0], opcode[`BSE_FILE_ACCESS],
                               bank_select_register, ext_mode, index_base);
        end
        ST_READ: begin
          operand <= is_file ? mem[mem_ptr] : opcode[7:0];
        end
        ST_PROC: begin
          result <= alu_diff;
          new_flags[`BSE_STAT_C]  <= alu_c;
          new_flags[`BSE_STAT_DC] <= alu_dc;
          new_flags[`BSE_STAT_Z]  <= alu_z;
          new_flags[`BSE_STAT_OV] <= alu_ov;
          new_flags[`BSE_STAT_N]  <= alu_n;
        end
        default: begin
        end
      endcase
    end
  end

  // Software registers plus the destination write of the final phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_mode             <= `BSE_RST_CTRL;
      work                 <= `BSE_RST_WORK;
      bank_select_register <= `BSE_RST_BANK;
      index_base           <= `BSE_RST_INDEX;
      flags                <= `BSE_RST_FLAGS;
      bad_op               <= 1'b0;
      opcode               <= `BSE_RST_INSTR;
      mem_addr             <= `BSE_RST_MEM_ADDR;
    end else begin
      if (commit_wr) begin
        case (paddr)
          `BSE_OFF_CTRL: begin
            ext_mode <= pwdata[`BSE_CTRL_EXT];
          end
          `BSE_OFF_INSTR: begin
            opcode <= pwdata[15:0];
            bad_op <= ~(instr_lit | instr_file);
          end
          `BSE_OFF_WORK: begin
            work <= pwdata[7:0];
          end
          `BSE_OFF_BANK: begin
            bank_select_register <= pwdata[3:0];
          end
          `BSE_OFF_INDEX: begin
            index_base <= pwdata[11:0];
          end
          `BSE_OFF_STATUS: begin
            flags <= pwdata[4:0];
            if (pwdata[`BSE_STAT_BADOP]) begin
              bad_op <= 1'b0;
            end
          end
          `BSE_OFF_MEM_ADDR: begin
            mem_addr <= pwdata[ADDR_W-1:0];
          end
          default: begin
          end
        endcase
      end
      if (state == ST_WRITE) begin
        flags <= new_flags;
        if (!(is_file && opcode[`BSE_FILE_DEST])) begin
          work <= result;
        end
      end
    end
  end

  // Data memory port: final-phase write-back has priority over software
  assign mem_we = ((state == ST_WRITE) && is_file && opcode[`BSE_FILE_DEST]) ||
                  (commit_wr && (paddr == `BSE_OFF_MEM_DATA));
  assign mem_wa = (state == ST_WRITE) ? mem_ptr : mem_addr;
  assign mem_wd = (state == ST_WRITE) ? result : pwdata[7:0];

  always @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

endmodule // bse_exec_unit

`default_nettype wire

// ### bse_exec_unit_properties.sv
// Checker for bus timing and instruction timing of the execute unit
`timescale 1ns/10ps
`default_nettype none
`include "bse_consts.vh"

module bse_exec_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        busy
);
  wire logic acc1 = psel && penable && !pready;
  wire logic commit = psel && penable && pready && pwrite &&
                      paddr == `BSE_OFF_INSTR;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  busy_four_cycles_a: assert property (
    $rose(busy) |-> busy[*4] ##1 !busy) else $error("busy length");
  busy_has_cause_a: assert property (
    $rose(busy) |-> $past(commit)) else $error("busy without start");
  access_wait_a: assert property (
    acc1 |=> pready) else $error("ready late");
  ready_pulse_a: assert property (
    pready |=> !pready) else $error("ready too long");
  idle_quiet_a: assert property (
    !psel |=> !pready && !pslverr && prdata == 32'h0)
    else $error("bus not quiet");
  err_with_ready_a: assert property (
    pslverr |-> pready) else $error("error without ready");
  busy_write_refused_a: assert property (
    acc1 && pwrite && busy |=> pslverr) else $error("write not refused");
  unmapped_err_a: assert property (
    acc1 && paddr > 12'h01c |=> pslverr) else $error("unmapped ok");
  mapped_read_a: assert property (
    acc1 && !pwrite && paddr <= 12'h01c && paddr[1:0] == 2'b00
    |=> !pslverr) else $error("read refused");

  cover property ($rose(busy));
  cover property (pready && pslverr);
  cover property ($fell(busy));
endmodule // bse_exec_props

bind bse_exec_unit bse_exec_props bse_exec_props_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .busy
);
`default_nettype wire

// ### bse_sub_alu.v
// Eight-bit subtractor with arithmetic status flags
`timescale 1ns/10ps
`default_nettype none

module bse_sub_alu (
  input  wire [7:0] minuend,
  input  wire [7:0] work,
  output wire [7:0] diff,
  output wire       flag_n,
  output wire       flag_ov,
  output wire       flag_c,
  output wire       flag_dc,
  output wire       flag_z
);

  wire [8:0] full_sum;
  wire [4:0] low_sum;

  // Two's complement: minuend plus inverted work plus one
  assign full_sum = {1'b0, minuend} + {1'b0, ~work} + 9'h001;
  assign low_sum  = {1'b0, minuend[3:0]} + {1'b0, ~work[3:0]} + 5'h01;
  assign diff     = full_sum[7:0];
  assign flag_c   = full_sum[8];
  assign flag_dc  = low_sum[4];
  assign flag_z   = (full_sum[7:0] == 8'h00);
  assign flag_n   = full_sum[7];
  assign flag_ov  = (minuend[7] ^ work[7]) & (minuend[7] ^ full_sum[7]);

endmodule // bse_sub_alu

`default_nettype wire

// ### byte_subtract_execute_unit_tb_top.sv
// Self-checking bench for the byte subtract execute unit
`timescale 1ns/10ps
`default_nettype none
`include "bse_consts.vh"

module byte_subtract_execute_unit_tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         busy;
  logic [31:0] rd_q;
  logic        er_q;
  logic        dst;
  logic [57:0] rows [0:9];
  logic [57:0] r;
  int          num_errors = 0;
  int          check_count = 0;
  int          i;

  bse_exec_unit bse_exec_unit_i (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .busy    (busy)
  );

  always #10 pclk = ~pclk;

  task test_done;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic ck(input [31:0] g, input [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task tmo;
    $display("[ERR] %0t wait %h %h", $time, pready, busy);
    num_errors++;
    test_done();
  endtask

  // One APB transfer; read data and error taken at the ready edge
  task automatic xf(input w, input [11:0] a, input [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
      tmo();
    rd_q = prdata;
    er_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 10) begin
      @(posedge pclk);
      k++;
    end
    if (busy !== 1'b0)
      tmo();
  endtask

  task automatic run(input [15:0] op);
    xf(1'b1, `BSE_OFF_INSTR, {16'h0, op});
    wait_idle();
  endtask

  initial begin
    // ext, opcode, memory address, memory, W, result, flags N OV Z DC C
    rows[0] = {1'b0, 16'h0802, 12'h000, 8'h00, 8'h01, 8'h01, 5'h03};
    rows[1] = {1'b0, 16'h0802, 12'h000, 8'h00, 8'h02, 8'h00, 5'h07};
    rows[2] = {1'b0, 16'h0802, 12'h000, 8'h00, 8'h03, 8'hff, 5'h10};
    rows[3] = {1'b0, 16'h0880, 12'h000, 8'h00, 8'h01, 8'h7f, 5'h09};
    rows[4] = {1'b0, 16'h5c5f, 12'h05f, 8'h02, 8'h05, 8'hfd, 5'h10};
    rows[5] = {1'b0, 16'h5e60, 12'hf60, 8'h02, 8'h02, 8'h00, 5'h07};
    rows[6] = {1'b0, 16'h5f33, 12'h533, 8'h50, 8'h10, 8'h40, 5'h03};
    rows[7] = {1'b1, 16'h5c5f, 12'h25f, 8'h09, 8'h03, 8'h06, 5'h03};
    rows[8] = {1'b1, 16'h5e60, 12'hf60, 8'h01, 8'h02, 8'hff, 5'h10};
    rows[9] = {1'b1, 16'h5d00, 12'h500, 8'h7f, 8'hff, 8'h80, 5'h1a};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xf(1'b1, `BSE_OFF_BANK, 32'h5);
    xf(1'b1, `BSE_OFF_INDEX, 32'h200);
    for (i = 0; i < 10; i++) begin
      r = rows[i];
      xf(1'b1, `BSE_OFF_CTRL, {31'h0, r[57]});
      xf(1'b1, `BSE_OFF_WORK, {24'h0, r[20:13]});
      xf(1'b1, `BSE_OFF_MEM_ADDR, {20'h0, r[40:29]});
      xf(1'b1, `BSE_OFF_MEM_DATA, {24'h0, r[28:21]});
      run(r[56:41]);
      dst = r[56:53] == 4'h5 && r[50];
      xf(1'b0, `BSE_OFF_WORK, 32'h0);
      ck(rd_q, {24'h0, dst ? r[20:13] : r[12:5]});
      xf(1'b0, `BSE_OFF_MEM_DATA, 32'h0);
      ck(rd_q, {24'h0, dst ? r[12:5] : r[28:21]});
      xf(1'b0, `BSE_OFF_STATUS, 32'h0);
      ck(rd_q & 32'h1f, {27'h0, r[4:0]});
    end
    // A write landing during execution is refused
    xf(1'b1, `BSE_OFF_WORK, 32'h0);
    xf(1'b1, `BSE_OFF_INSTR, 32'h0801);
    xf(1'b1, `BSE_OFF_WORK, 32'h55);
    ck({31'h0, er_q}, 32'h1);
    wait_idle();
    xf(1'b0, `BSE_OFF_WORK, 32'h0);
    ck(rd_q, 32'h01);
    run(16'hffff);
    xf(1'b0, `BSE_OFF_STATUS, 32'h0);
    ck(rd_q & 32'h300, 32'h200);
    xf(1'b1, `BSE_OFF_STATUS, 32'h200);
    xf(1'b0, `BSE_OFF_STATUS, 32'h0);
    ck(rd_q & 32'h200, 32'h0);
    xf(1'b0, 12'h020, 32'h0);
    ck({rd_q[30:0], er_q}, 32'h1);
    xf(1'b1, 12'h020, 32'hff);
    ck({31'h0, er_q}, 32'h1);
    // Reset while idle clears every register at offsets 0x000 to 0x018
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 7; i++) begin
      xf(1'b0, 12'(4 * i), 32'h0);
      ck(rd_q, 32'h0);
    end
    test_done();
  end
endmodule // byte_subtract_execute_unit_tb_top
`default_nettype wire
